// ==== pkg/tps_pkg.sv ====
package tps_pkg;

  // Word and address widths of the table memory
  localparam int DATA_W_DEF     = 16;
  localparam int ADDR_W_DEF     = 10;
  // Length operand is one byte, 0 to FF
  localparam int LEN_W          = 8;
  localparam int FIFO_DEPTH_DEF = 4;

  // Word offsets inside a table, and the count decrement
  localparam int COUNT_OFFSET   = 0;
  localparam int ENTRY1_OFFSET  = 1;
  localparam int SHIFT_STEP     = 1;
  localparam int COUNT_DEC      = 1;

  // Values after reset
  localparam logic FLAG_RESET   = 1'b0;
  localparam logic BUSY_RESET   = 1'b0;
  localparam logic DONE_RESET   = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_DEST,
    ST_SHIFT,
    ST_COUNT,
    ST_FINISH
  } tps_state_type;

endpackage : tps_pkg

// ==== rtl/tps_fifo.sv ====
`timescale 1ns/1ps
module tps_fifo import tps_pkg::*; #(
  parameter int WIDTH = DATA_W_DEF,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clockEnable,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("tps_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg, wrPtr_next;
  logic [PTR_W-1:0] rdPtr_reg, rdPtr_next;
  logic [PTR_W:0]   fill_reg,  fill_next;
  logic             full_reg,  full_next;
  logic             valid_reg, valid_next;
  logic             doPush, doPop;

  ////////////////////////////////////////////////////////////////////////////
  // Flags are kept as registers so both handshakes come from flip-flops
  always_comb begin
    doPush     = inValid && !full_reg;
    doPop      = valid_reg && outReady;
    wrPtr_next = doPush ? wrPtr_reg + 1'b1 : wrPtr_reg;
    rdPtr_next = doPop ? rdPtr_reg + 1'b1 : rdPtr_reg;
    fill_next  = fill_reg;
    if (doPush && !doPop) begin
      fill_next = fill_reg + 1'b1;
    end else if (doPop && !doPush) begin
      fill_next = fill_reg - 1'b1;
    end
    full_next  = (fill_next == (PTR_W+1)'(DEPTH));
    valid_next = (fill_next != '0);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      fill_reg  <= '0;
      full_reg  <= 1'b0;
      valid_reg <= 1'b0;
    end else if (clockEnable) begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      fill_reg  <= fill_next;
      full_reg  <= full_next;
      valid_reg <= valid_next;
    end
  end

  always_ff @(posedge clock) begin
    if (clockEnable && doPush) begin
      store[wrPtr_reg] <= inData;
    end
  end

  assign inReady  = !full_reg;
  assign outValid = valid_reg;
  assign outData  = store[rdPtr_reg];

endmodule : tps_fifo

// ==== rtl/tps_table_pop.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Each successful execution removes one entry and writes it to the destination word.
// - Remaining entries move up one word toward the table start.
// - Word at table start is the entry count; entries follow it.
// - Each successful execution lowers the count word by one.
// - Count zero or above length operand: nothing moves, flag is raised.
// - Flag is raised when an execution finds the count word at zero or takes it to zero.
// - Executes once per scan while enabled, never in a disabled scan.
// - Flag holds until the scan ends or the next flag user runs.
// - First data word after the count word is entry one.
module tps_table_pop import tps_pkg::*; #(
  parameter int DATA_W     = DATA_W_DEF,
  parameter int ADDR_W     = ADDR_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clockEnable,
  input  wire logic              memWrEn,
  input  wire logic [ADDR_W-1:0] memWrAddr,
  input  wire logic [DATA_W-1:0] memWrData,
  input  wire logic [ADDR_W-1:0] memRdAddr,
  output logic      [DATA_W-1:0] memRdData,
  input  wire logic              scanStart,
  input  wire logic              enableInputContact,
  input  wire logic [LEN_W-1:0]  lengthOperand,
  input  wire logic [ADDR_W-1:0] tableAddr,
  input  wire logic [ADDR_W-1:0] destAddr,
  output logic                   busy,
  output logic                   opDone,
  output logic                   tableStatusFlag,
  output logic                   popValid,
  input  wire logic              popReady,
  output logic      [DATA_W-1:0] popData
);

  localparam int DEPTH = 1 << ADDR_W;

  initial begin
    if (DATA_W < LEN_W || ADDR_W < 2 || ADDR_W > 20)
      $error("tps_table_pop: DATA_W must hold the length, ADDR_W 2 to 20");
  end

  function automatic logic [ADDR_W-1:0] addrAt(
    input logic [ADDR_W-1:0] base,
    input logic [LEN_W-1:0]  off
  );
    addrAt = base + ADDR_W'(off);
  endfunction : addrAt

  ////////////////////////////////////////////////////////////////////////////
  // Word memory holding the tables
  logic [DATA_W-1:0]  mem [DEPTH];
  logic               wrEn;
  logic [ADDR_W-1:0]  wrAddr;
  logic [DATA_W-1:0]  wrData;
  logic [DATA_W-1:0]  rdData_reg, rdData_next;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  tps_state_type      state_reg,   state_next;
  logic [ADDR_W-1:0]  base_reg,    base_next;
  logic [ADDR_W-1:0]  dest_reg,    dest_next;
  logic [LEN_W-1:0]   length_reg,  length_next;
  logic [DATA_W-1:0]  count_reg,   count_next;
  logic [LEN_W-1:0]   index_reg,   index_next;
  logic               ranScan_reg, ranScan_next;
  logic               flag_reg,    flag_next;
  logic               busy_reg,    busy_next;
  logic               done_reg,    done_next;
  logic               fifoValid;
  logic               fifoReady;
  logic [DATA_W-1:0]  headWord;
  logic [DATA_W-1:0]  countWord;
  logic               flagSet;

  assign headWord  = mem[addrAt(base_reg, LEN_W'(ENTRY1_OFFSET))];
  assign countWord = mem[addrAt(base_reg, LEN_W'(COUNT_OFFSET))];

  always_comb begin
    state_next   = state_reg;
    base_next    = base_reg;
    dest_next    = dest_reg;
    length_next  = length_reg;
    count_next   = count_reg;
    index_next   = index_reg;
    ranScan_next = ranScan_reg;
    busy_next    = busy_reg;
    done_next    = 1'b0;
    flagSet      = 1'b0;
    wrEn         = 1'b0;
    wrAddr       = memWrAddr;
    wrData       = memWrData;
    fifoValid    = 1'b0;
    // Host writes are dropped while an execution owns the memory
    if (!busy_reg && memWrEn) begin
      wrEn = 1'b1;
    end
    if (scanStart) begin
      ranScan_next = 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        // A new scan that arrives with a start request still allows one run
        if (enableInputContact && (!ranScan_reg || scanStart)) begin
          base_next    = tableAddr;
          dest_next    = destAddr;
          length_next  = lengthOperand;
          ranScan_next = 1'b1;
          busy_next    = 1'b1;
          state_next   = ST_CHECK;
        end
      end
      ST_CHECK: begin
        count_next = countWord;
        index_next = LEN_W'(ENTRY1_OFFSET);
        if (countWord == '0 ||
            countWord > DATA_W'(length_reg)) begin
          flagSet    = 1'b1;
          state_next = ST_FINISH;
        end else begin
          state_next = ST_DEST;
        end
      end
      ST_DEST: begin
        // Stall until the FIFO takes the word, so data is never lost
        fifoValid = 1'b1;
        if (fifoReady) begin
          wrEn       = 1'b1;
          wrAddr     = dest_reg;
          wrData     = headWord;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (DATA_W'(index_reg) >= count_reg) begin
          // Last valid slot is left as it was
          state_next = ST_COUNT;
        end else begin
          wrEn       = 1'b1;
          wrAddr     = addrAt(base_reg, index_reg);
          wrData     = mem[addrAt(base_reg,
                           index_reg + LEN_W'(SHIFT_STEP))];
          index_next = index_reg + LEN_W'(SHIFT_STEP);
        end
      end
      ST_COUNT: begin
        wrEn       = 1'b1;
        wrAddr     = base_reg;
        wrData     = count_reg - DATA_W'(COUNT_DEC);
        count_next = wrData;
        if (count_reg == DATA_W'(COUNT_DEC)) begin
          flagSet = 1'b1;
        end
        state_next = ST_FINISH;
      end
      ST_FINISH: begin
        busy_next  = 1'b0;
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        busy_next  = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
    // Set wins over the scan-end clear
    if (flagSet) begin
      flag_next = 1'b1;
    end else if (scanStart || state_reg == ST_CHECK) begin
      flag_next = 1'b0;
    end else begin
      flag_next = flag_reg;
    end
    rdData_next = mem[memRdAddr];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg   <= ST_IDLE;
      base_reg    <= '0;
      dest_reg    <= '0;
      length_reg  <= '0;
      count_reg   <= '0;
      index_reg   <= '0;
      ranScan_reg <= 1'b0;
      flag_reg    <= FLAG_RESET;
      busy_reg    <= BUSY_RESET;
      done_reg    <= DONE_RESET;
      rdData_reg  <= '0;
    end else if (clockEnable) begin
      state_reg   <= state_next;
      base_reg    <= base_next;
      dest_reg    <= dest_next;
      length_reg  <= length_next;
      count_reg   <= count_next;
      index_reg   <= index_next;
      ranScan_reg <= ranScan_next;
      flag_reg    <= flag_next;
      busy_reg    <= busy_next;
      done_reg    <= done_next;
      rdData_reg  <= rdData_next;
    end
  end

  // Memory has no reset: the count word is never initialised by the block
  always_ff @(posedge clock) begin
    if (clockEnable && wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Removed words also leave as a stream through a small FIFO
  tps_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock       (clock),
    .rst_n       (rst_n),
    .clockEnable (clockEnable),
    .inValid     (fifoValid),
    .inReady     (fifoReady),
    .inData      (headWord),
    .outValid    (popValid),
    .outReady    (popReady),
    .outData     (popData)
  );

  assign memRdData       = rdData_reg;
  assign busy            = busy_reg;
  assign opDone          = done_reg;
  assign tableStatusFlag = flag_reg;

endmodule : tps_table_pop

// ==== dv/tps_table_pop_monitor.sv ====
`timescale 1ns/1ps
module tps_table_pop_monitor import tps_pkg::*; #(
  parameter int DATA_W = DATA_W_DEF
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              clockEnable,
  input wire logic              scanStart,
  input wire logic              enableInputContact,
  input wire logic              busy,
  input wire logic              opDone,
  input wire logic              tableStatusFlag,
  input wire logic              popValid,
  input wire logic              popReady,
  input wire logic [DATA_W-1:0] popData
);
  default clocking cb @(posedge clock); endclocking
  // A frozen block answers nothing, so attempts over a freeze are dropped
  default disable iff (!rst_n || !clockEnable);
  ////////////////////////////////////////////////////////////
  // Refused runs are two cycles long, valid ones at least five
  sequence shortRun;
    !busy ##1 busy [*2] ##1 !busy;
  endsequence
  sequence takeNow;
    !busy && enableInputContact && scanStart;
  endsequence
  a_refuse_flag:
    assert property (shortRun |-> tableStatusFlag)
    else $error("short run without flag");
  a_take_on:
    assert property (takeNow |=> busy)
    else $error("enabled scan did not start");
  a_idle_off:
    assert property (!busy && !enableInputContact |=> !busy)
    else $error("run without enable");
  a_done_follows:
    assert property ($fell(busy) |-> opDone)
    else $error("run ended without done");
  a_done_single:
    assert property (opDone |=> !opDone)
    else $error("done longer than one cycle");
  a_scan_clears:
    assert property (scanStart && !busy |=> !tableStatusFlag)
    else $error("flag survived scan boundary");
  a_pop_hold:
    assert property (popValid && !popReady |=> popValid && $stable(popData))
    else $error("stalled word changed");
  a_push_in_run:
    assert property ($rose(popValid) |-> $past(busy))
    else $error("word pushed outside a run");
endmodule : tps_table_pop_monitor

// ==== dv/tps_seq_model.sv ====
`timescale 1ns/1ps
module tps_seq_model import tps_pkg::*; #(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input  wire logic              clock,
  input  wire logic              kick,
  input  wire logic              hold,
  input  wire logic              en,
  input  wire logic [LEN_W-1:0]  lenIn,
  input  wire logic [ADDR_W-1:0] tabIn,
  input  wire logic [ADDR_W-1:0] dstIn,
  output logic                   scanStart = 1'b0,
  output logic                   enableInputContact = 1'b0,
  output logic      [LEN_W-1:0]  lengthOperand = 8'h00,
  output logic      [ADDR_W-1:0] tableAddr = '0,
  output logic      [ADDR_W-1:0] destAddr = '0
);
  // One-shot enable unless held, so one removal per kick
  always @(posedge clock) begin
    scanStart          <= kick;
    enableInputContact <= en & (kick | hold);
    if (kick) begin
      lengthOperand <= lenIn;
      tableAddr     <= tabIn;
      destAddr      <= dstIn;
    end
  end
endmodule : tps_seq_model

// ==== dv/tps_table_pop_tb_top.sv ====
`timescale 1ns/1ps
module tps_table_pop_tb_top import tps_pkg::*; ;
  localparam logic [9:0] BASE = 10'h100;
  localparam logic [9:0] DEST = 10'h200;
  logic        clock = 1'b0, rst_n = 1'b0, memWrEn = 1'b0;
  logic        popReady = 1'b0, kick = 1'b0, hold = 1'b0;
  logic        en = 1'b1, stall = 1'b0, ce = 1'b1;
  logic [9:0]  memWrAddr = 10'h000, memRdAddr = 10'h000;
  logic [9:0]  tableAddr, destAddr;
  logic [15:0] memWrData = 16'h0000, memRdData, popData, dstVal;
  logic [7:0]  lenIn = 8'h06, lengthOperand;
  logic        scanStart, enableInputContact, busy, opDone;
  logic        tableStatusFlag, popValid;
  logic [31:0] rnd;
  logic [15:0] tbl [0:7];
  logic [15:0] q [$];
  integer      seed = 32'h48F633C8;
  int          failures = 0, total_checks = 0;

  always #5 clock = ~clock;

  tps_table_pop dut (.clock, .rst_n, .clockEnable(ce), .memWrEn,
    .memWrAddr, .memWrData, .memRdAddr, .memRdData, .scanStart,
    .enableInputContact, .lengthOperand, .tableAddr, .destAddr, .busy,
    .opDone, .tableStatusFlag, .popValid, .popReady, .popData);
  tps_seq_model seq (.clock, .kick, .hold, .en, .lenIn, .tabIn(BASE),
    .dstIn(DEST), .scanStart, .enableInputContact, .lengthOperand,
    .tableAddr, .destAddr);
  ////////////////////////////////////////////////////////////
  task automatic check(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  function automatic logic okCount(logic [15:0] c, logic [7:0] len);
    return c != 16'h0000 && c <= {8'h00, len};
  endfunction : okCount

  // Random sink stalls; stall holds it off to fill the buffer
  always @(posedge clock) begin
    rnd = $random(seed);
    popReady <= !stall && rnd[0];
    if (popValid && popReady) begin
      check("popData", q.size() != 0 ? q[0] : 16'hXXXX,
            popData);
      if (q.size() != 0)
        void'(q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic rd(logic [9:0] a, output logic [15:0] d);
    memRdAddr <= a;
    repeat (2) @(posedge clock);
    d = memRdData;
  endtask : rd

  task automatic load(int c);
    tbl[0] = 16'(c);
    for (int i = 1; i < 8; i++)
      tbl[i] = 16'($random(seed));
    for (int i = 0; i < 8; i++) begin
      memWrEn   <= 1'b1;
      memWrAddr <= 10'(BASE + i);
      memWrData <= tbl[i];
      @(posedge clock);
    end
    memWrEn <= 1'b0;
    @(posedge clock);
  endtask : load

  task automatic run(logic [7:0] len, bit jam);
    lenIn <= len;
    kick  <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    if (jam) begin
      repeat (30) @(posedge clock);
      check("stalled busy", 16'h0001, 16'(busy));
      stall <= 1'b0;
    end
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock);
      if (opDone === 1'b1)
        return;
    end
    failures++;
    finish_test();
  endtask : run

  task automatic doPop(logic [7:0] len, bit jam);
    logic        good;
    logic [15:0] got;
    good = okCount(tbl[0], len);
    if (good) begin
      q.push_back(tbl[1]);
      dstVal = tbl[1];
      for (int i = 1; i < tbl[0]; i++)
        tbl[i] = tbl[i + 1];
      tbl[0] = tbl[0] - 16'h0001;
    end
    run(len, jam);
    check("flag", 16'(!good || tbl[0] == 16'h0000),
          16'(tableStatusFlag));
    for (int i = 0; i < 8; i++) begin
      rd(10'(BASE + i), got);
      check("table word", tbl[i], got);
    end
    rd(DEST, got);
    check("dest word", dstVal, got);
  endtask : doPop
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int r = 0; r < 3; r++) begin
      load(r == 0 ? 6 : 1 + $unsigned($random(seed)) % 6);
      repeat (7) doPop(8'h06, 1'b0);
    end
    load(7);
    doPop(8'h06, 1'b0);
    doPop(8'h00, 1'b0);
    load(2);
    hold <= 1'b1;
    doPop(8'h06, 1'b0);
    repeat (8) begin
      @(posedge clock);
      check("rerun busy", 16'h0000, 16'(busy));
    end
    doPop(8'h06, 1'b0);
    hold <= 1'b0;
    en   <= 1'b0;
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    repeat (3) @(posedge clock);
    check("cleared flag", 16'h0000, 16'(tableStatusFlag));
    check("idle busy", 16'h0000, 16'(busy));
    // Count is zero now, so a live start would raise the flag
    en   <= 1'b1;
    ce   <= 1'b0;
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    repeat (4) @(posedge clock);
    check("frozen flag", 16'h0000, 16'(tableStatusFlag));
    check("frozen busy", 16'h0000, 16'(busy));
    ce    <= 1'b1;
    stall <= 1'b1;
    load(6);
    for (int i = 0; i < 5; i++)
      doPop(8'h06, i == 4);
    for (int i = 0; i < 500 && (popValid !== 1'b0); i++)
      @(posedge clock);
    check("left valid", 16'h0000, 16'(popValid));
    check("left words", 16'h0000, 16'(q.size()));
    finish_test();
  end
endmodule : tps_table_pop_tb_top

bind tps_table_pop tps_table_pop_monitor #(.DATA_W(DATA_W)) mon (.clock,
  .rst_n, .clockEnable, .scanStart, .enableInputContact, .busy, .opDone,
  .tableStatusFlag, .popValid, .popReady, .popData);
